// [hw/fault_seq_pkg.sv]
// Constants and types for the buck fault-protection sequencer
// Contract
// R1: valley judged sourcing current; sink judged otherwise
// R2: valley trip at cycle end skips next pulse
// R3: persistent valley limiting steps reference down
// R4: limiting lasting 4096 cycles enters hiccup
// R5: after overload, reference soft-steps back up
// R6: sink trip turns low side off immediately
// R7: sink limit holds both drives off
// R8: 3-bit counter increments on valley cycles
// R9: counter decrements otherwise, saturating at zero
// R10: full counter stops drivers, waits 4096, restarts
// R11: hiccup protection also active during soft-start
// R12: undervoltage lockout holds both drives low
// R13: overtemperature forces drives low until cleared
// R14: thermal shutdown resets soft-start state
// R15: too-short demanded pulse is skipped instead
// R16: soft-start steps 1/64 over 2048 cycles
// R17: power-good driven low during hiccup timeout
// R18: prebias start: drives off until first pulse
// R19: counters cleared at restart and in lockout
package fault_seq_pkg;
  localparam int CLK_PERIOD_NS = 5;
  localparam int MIN_ON_NS = 125;
  localparam int MIN_ON_CLKS = (MIN_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SW_PERIOD_CLKS = 200;
  localparam int HICCUP_SW_CYCLES = 4096;
  localparam int LIMIT_SW_CYCLES = 4096;
  localparam int SS_SW_CYCLES = 2048;
  localparam int REF_STEPS = 64;
  localparam int SS_STEP_SW_CYCLES = SS_SW_CYCLES / REF_STEPS;
  localparam int REF_W = 7;
  localparam logic [6:0] REF_FULL = 7'h40;
  localparam logic [6:0] REF_RESET = 7'h00;
  localparam int OC_W = 3;
  localparam logic [2:0] OC_FULL = 3'h7;
  localparam logic [2:0] OC_RESET = 3'h0;
  localparam int SYNC_W = 7;
  localparam int IDX_VALLEY = 0;
  localparam int IDX_SINK = 1;
  localparam int IDX_BELOW = 2;
  localparam int IDX_UVLO = 3;
  localparam int IDX_OTEMP = 4;
  localparam int IDX_PWM = 5;
  localparam int IDX_PG = 6;
  typedef enum logic [1:0] {PH_LOCKOUT, PH_SOFTSTART, PH_RUN, PH_HICCUP} phase_t;
endpackage

// [hw/sync_if.sv]
// Raw and synchronised comparator levels between sequencer and synchroniser
`timescale 1ns/10ps
interface sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] synced;
  modport sync_side (input raw, output synced);
  modport user_side (output raw, input synced);
endinterface

// [hw/pin_sync.sv]
// Two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/10ps
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic rst,
  sync_if.sync_side pins
);
  logic [W-1:0] meta_q;
  logic [W-1:0] stable_q;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      meta_q <= '0;
      stable_q <= '0;
    end
    else
    begin
      meta_q <= pins.raw;
      stable_q <= meta_q;
    end
  end

  assign pins.synced = stable_q;
endmodule

// [hw/buck_fault_protection_sequencer.sv]
// Fault-protection sequencer: current limits, hiccup, lockouts, soft-start
`timescale 1ns/10ps
module buck_fault_protection_sequencer #(
  parameter int SW_PERIOD = fault_seq_pkg::SW_PERIOD_CLKS,
  parameter int HICCUP_CYCLES = fault_seq_pkg::HICCUP_SW_CYCLES,
  parameter int LIMIT_CYCLES = fault_seq_pkg::LIMIT_SW_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic valley_trip,
  input wire logic sink_trip,
  input wire logic current_sense_pos_below,
  input wire logic uvlo_flag,
  input wire logic overtemp_flag,
  input wire logic pwm_compare,
  input wire logic output_ok_flag_compare,
  output logic high_side_drive,
  output logic low_side_drive,
  output logic output_ok_flag_out,
  output logic output_ok_flag_oe_n,
  output logic [fault_seq_pkg::REF_W-1:0] ref_level,
  output logic hiccup_active
);
  import fault_seq_pkg::*;

  localparam int SW_W = $clog2(SW_PERIOD);
  localparam int HC_W = $clog2(HICCUP_CYCLES);
  localparam int LC_W = $clog2(LIMIT_CYCLES);
  localparam int ST_W = $clog2(SS_STEP_SW_CYCLES);
  localparam logic [SW_W-1:0] SW_LAST = SW_W'(SW_PERIOD - 1);
  localparam logic [HC_W-1:0] HC_LAST = HC_W'(HICCUP_CYCLES - 1);
  localparam logic [LC_W-1:0] LC_LAST = LC_W'(LIMIT_CYCLES - 1);
  localparam logic [ST_W-1:0] ST_LAST = ST_W'(SS_STEP_SW_CYCLES - 1);
  localparam logic [SW_W-1:0] MIN_ON = SW_W'(MIN_ON_CLKS);

  sync_if #(.W(SYNC_W)) pins ();

  assign pins.raw = {output_ok_flag_compare, pwm_compare, overtemp_flag, uvlo_flag,
                     current_sense_pos_below, sink_trip, valley_trip};

  pin_sync #(.W(SYNC_W)) u_sync (
    .clock(clock),
    .rst(rst),
    .pins(pins)
  );

  logic s_valley;
  logic s_sink;
  logic s_below;
  logic s_fault;
  logic s_pwm;
  logic s_pg;
  assign s_valley = pins.synced[IDX_VALLEY];
  assign s_sink = pins.synced[IDX_SINK];
  assign s_below = pins.synced[IDX_BELOW];
  // R13: thermal fault joins lockout
  assign s_fault = pins.synced[IDX_UVLO] | pins.synced[IDX_OTEMP];
  assign s_pwm = pins.synced[IDX_PWM];
  assign s_pg = pins.synced[IDX_PG];

  phase_t phase_q;
  logic [SW_W-1:0] sw_cnt_q;
  logic [SW_W-1:0] demand_q;
  logic [OC_W-1:0] oc_q;
  logic [LC_W-1:0] limit_q;
  logic [HC_W-1:0] hiccup_q;
  logic [ST_W-1:0] step_q;
  logic [REF_W-1:0] ref_q;
  logic skip_valley_q;
  logic short_q;
  logic sink_hold_q;
  logic first_pulse_q;
  logic high_q;
  logic low_q;
  logic [1:0] low_hist_q;
  logic pg_oe_n_q;

  logic cycle_start;
  logic cycle_end;
  logic active;
  logic valley_now;
  logic sink_now;
  logic limit_done;
  logic go_hiccup;
  logic high_d;
  logic low_d;

  assign cycle_start = (sw_cnt_q == '0);
  assign cycle_end = (sw_cnt_q == SW_LAST);
  assign active = (phase_q == PH_SOFTSTART) || (phase_q == PH_RUN);
  // R1: direction qualifies each comparator; synced level must stem from low-side on-time
  assign valley_now = low_q & low_hist_q[1] & s_valley & s_below;
  assign sink_now = low_q & low_hist_q[1] & s_sink & ~s_below;
  // R4: limiting duration expiry
  assign limit_done = cycle_end & valley_now & (limit_q == LC_LAST);
  // R10: full counter or long limiting
  assign go_hiccup = active & ((oc_q == OC_FULL) | limit_done);

  // Switching period divider
  always_ff @(posedge clock)
  begin
    if (rst)
      sw_cnt_q <= '0;
    else if (cycle_end)
      sw_cnt_q <= '0;
    else
      sw_cnt_q <= sw_cnt_q + 1'b1;
  end

  // R12: lockout on fault
  always_ff @(posedge clock)
  begin
    if (rst || s_fault)
      phase_q <= PH_LOCKOUT;
    else
    begin
      unique case (phase_q)
        PH_LOCKOUT:
          phase_q <= PH_SOFTSTART;
        PH_SOFTSTART:
          // R11: hiccup checked during soft-start
          if (go_hiccup)
            phase_q <= PH_HICCUP;
          else if (cycle_end && ref_q == REF_FULL && !valley_now)
            phase_q <= PH_RUN;
        PH_RUN:
          if (go_hiccup)
            phase_q <= PH_HICCUP;
          // R5: recover through soft-start stepping
          else if (cycle_end && !valley_now && ref_q != REF_FULL)
            phase_q <= PH_SOFTSTART;
        PH_HICCUP:
          // R10: restart after timeout
          if (cycle_end && hiccup_q == HC_LAST)
            phase_q <= PH_SOFTSTART;
      endcase
    end
  end

  // Hiccup timeout counter
  always_ff @(posedge clock)
  begin
    if (rst || phase_q != PH_HICCUP)
      hiccup_q <= '0;
    else if (cycle_end)
      hiccup_q <= hiccup_q + 1'b1;
  end

  // R19: overcurrent counter cleared outside active phases
  always_ff @(posedge clock)
  begin
    if (rst || !active)
      oc_q <= OC_RESET;
    else if (cycle_end)
    begin
      // R8: count up on valley cycle
      if (valley_now && oc_q != OC_FULL)
        oc_q <= oc_q + 1'b1;
      // R9: count down, stop at zero
      else if (!valley_now && oc_q != OC_RESET)
        oc_q <= oc_q - 1'b1;
    end
  end

  // R19: limit duration timer cleared too
  always_ff @(posedge clock)
  begin
    if (rst || !active)
      limit_q <= '0;
    else if (cycle_end)
      limit_q <= valley_now ? limit_q + 1'b1 : '0;
  end

  // R14: reference restarts from zero after lockout
  always_ff @(posedge clock)
  begin
    if (rst || phase_q == PH_LOCKOUT || phase_q == PH_HICCUP)
    begin
      ref_q <= REF_RESET;
      step_q <= '0;
    end
    else if (cycle_end)
    begin
      step_q <= step_q + 1'b1;
      // R3: roll back reference while limiting
      if (valley_now)
      begin
        if (ref_q != REF_RESET)
          ref_q <= ref_q - 1'b1;
      end
      // R16: one step each 32 cycles
      else if (phase_q == PH_SOFTSTART && step_q == ST_LAST && ref_q != REF_FULL)
        ref_q <= ref_q + 1'b1;
    end
  end

  // Per-cycle skip decisions and sink hold
  always_ff @(posedge clock)
  begin
    if (rst || !active)
    begin
      skip_valley_q <= 1'b0;
      short_q <= 1'b0;
      demand_q <= '0;
      sink_hold_q <= 1'b0;
    end
    else
    begin
      if (cycle_end)
      begin
        // R2: valley at end of low-side on-time
        skip_valley_q <= valley_now;
        // R15: demand shorter than minimum on-time
        short_q <= (demand_q != '0) && (demand_q < MIN_ON);
      end
      if (cycle_end)
        demand_q <= '0;
      else if (s_pwm && demand_q != SW_LAST)
        demand_q <= demand_q + 1'b1;
      if (cycle_end)
        sink_hold_q <= 1'b0;
      // R7: hold both off for rest of cycle
      else if (sink_now)
        sink_hold_q <= 1'b1;
    end
  end

  always_comb
  begin
    high_d = 1'b0;
    if (active && !s_fault && !go_hiccup && !sink_hold_q && !sink_now)
    begin
      if (cycle_start)
        // R2: no pulse after a valley-limited cycle
        // R15: skip too-short pulses
        high_d = s_pwm && !skip_valley_q && !short_q;
      else
        high_d = high_q && s_pwm;
    end
    // R18: low side waits for first pulse
    // R6: sink trip cuts low side now
    low_d = active && !s_fault && !go_hiccup && first_pulse_q && !high_d && !high_q
            && !sink_hold_q && !sink_now;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      high_q <= 1'b0;
      low_q <= 1'b0;
      low_hist_q <= 2'h0;
    end
    else
    begin
      high_q <= high_d;
      low_q <= low_d;
      low_hist_q <= {low_hist_q[0], low_q};
    end
  end

  // R18: first commanded pulse releases low side
  always_ff @(posedge clock)
  begin
    if (rst || !active)
      first_pulse_q <= 1'b0;
    else if (high_d)
      first_pulse_q <= 1'b1;
  end

  // R17: power-good pulled low during hiccup
  always_ff @(posedge clock)
  begin
    if (rst)
      pg_oe_n_q <= 1'b0;
    else
      pg_oe_n_q <= s_pg && phase_q != PH_HICCUP && phase_q != PH_LOCKOUT;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      output_ok_flag_out <= 1'b0;
      hiccup_active <= 1'b0;
    end
    else
    begin
      output_ok_flag_out <= 1'b0;
      hiccup_active <= (phase_q == PH_HICCUP);
    end
  end

  assign high_side_drive = high_q;
  assign low_side_drive = low_q;
  assign output_ok_flag_oe_n = pg_oe_n_q;
  assign ref_level = ref_q;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence valley_cycle;
    active && cycle_end && valley_now && !go_hiccup;
  endsequence

  sequence quiet_cycle;
    active && cycle_end && !valley_now && !go_hiccup;
  endsequence

  AST_UVLO_OFF: assert property (pins.synced[IDX_UVLO] |=> !high_q && !low_q) // R12
    else $error("drive active during undervoltage lockout");
  AST_OTEMP_OFF: assert property (pins.synced[IDX_OTEMP] |=> ##1 ref_q == REF_RESET && !high_q) // R13
    else $error("thermal shutdown did not stop drive or reset ramp");
  AST_SKIP_PULSE: assert property (valley_cycle |=> !high_q ##1 !high_q) // R2
    else $error("pulse issued after valley limit");
  AST_REF_ROLLBACK: assert property (valley_cycle ##0 ref_q != REF_RESET |=> ref_q == $past(ref_q) - 1'b1) // R3
    else $error("reference not rolled back");
  AST_SINK_LOW_OFF: assert property (sink_now |=> !low_q) // R6
    else $error("low side stayed on after sink trip");
  AST_SINK_BOTH_OFF: assert property (sink_hold_q && !cycle_end |=> !high_q && !low_q) // R7
    else $error("drive active during sink hold");
  AST_OC_UP: assert property (valley_cycle ##0 oc_q < 3'h6 |=> oc_q == $past(oc_q) + 1'b1) // R8
    else $error("overcurrent count did not increment");
  AST_OC_FLOOR: assert property (quiet_cycle ##0 oc_q == OC_RESET |=> oc_q == OC_RESET) // R9
    else $error("overcurrent count wrapped below zero");
  AST_HICCUP_IN: assert property (active && oc_q == OC_FULL |=> phase_q == PH_HICCUP ##1 !high_q && !low_q) // R10
    else $error("full counter did not enter hiccup");
  AST_PG_LOW: assert property (phase_q == PH_HICCUP |=> !pg_oe_n_q) // R17
    else $error("power-good released during hiccup");
  AST_PREBIAS: assert property (!first_pulse_q |=> !low_q) // R18
    else $error("low side on before first pulse");
  AST_STEP_UP: assert property (phase_q == PH_SOFTSTART && cycle_end && step_q != ST_LAST && !valley_now |=> ref_q == $past(ref_q)) // R16
    else $error("reference stepped off schedule");
endmodule

// [verif/fault_far_side.sv]
// Behavioural current comparators and PWM comparator at the far side
`timescale 1ns/10ps
module fault_far_side #(
  parameter int P = 48
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic low_side_drive,
  input wire logic overload,
  input wire logic reverse,
  input wire logic sink,
  input wire logic [7:0] demand,
  output logic valley_trip,
  output logic sink_trip,
  output logic current_sense_pos_below,
  output logic pwm_compare
);
  int cnt;
  always_ff @(posedge clock)
  begin
    if (rst || cnt == P - 1)
      cnt <= 0;
    else
      cnt <= cnt + 1;
  end
  // Sense comparators only mean something while the low side conducts
  assign valley_trip = low_side_drive ? overload : cnt[0];
  assign sink_trip = low_side_drive ? sink : ~cnt[0];
  assign current_sense_pos_below = low_side_drive ? ~reverse : cnt[1];
  // Leads the cycle start to cover the input synchroniser
  assign pwm_compare = ((cnt + 2) % P) < int'(demand);
endmodule

// [verif/buck_fault_protection_sequencer_test.sv]
// Self-checking bench for the fault-protection sequencer
`timescale 1ns/10ps
module buck_fault_protection_sequencer_test;
  import fault_seq_pkg::*;
  localparam int P = 48;
  localparam int HC = 8;
  logic clock = 0;
  logic rst = 1;
  logic uvlo_flag = 0;
  logic overtemp_flag = 0;
  logic output_ok_flag_compare = 1;
  logic overload = 0;
  logic reverse = 0;
  logic sink = 0;
  logic [7:0] demand = 8'h00;
  logic [31:0] seed = 32'hF076;
  logic valley_trip, sink_trip, current_sense_pos_below, pwm_compare;
  logic high_side_drive, low_side_drive, output_ok_flag_out, output_ok_flag_oe_n;
  logic hiccup_active;
  logic [REF_W-1:0] ref_level;
  int miscompares = 0;
  int n_tests = 0;
  int hs, ls, hic, bad, t, d;

  buck_fault_protection_sequencer #(.SW_PERIOD(P), .HICCUP_CYCLES(HC), .LIMIT_CYCLES(16))
    i_buck_fault_protection_sequencer (.clock(clock), .rst(rst), .valley_trip(valley_trip),
    .sink_trip(sink_trip), .current_sense_pos_below(current_sense_pos_below),
    .uvlo_flag(uvlo_flag), .overtemp_flag(overtemp_flag), .pwm_compare(pwm_compare),
    .output_ok_flag_compare(output_ok_flag_compare), .high_side_drive(high_side_drive),
    .low_side_drive(low_side_drive), .output_ok_flag_out(output_ok_flag_out),
    .output_ok_flag_oe_n(output_ok_flag_oe_n), .ref_level(ref_level),
    .hiccup_active(hiccup_active));

  fault_far_side #(.P(P)) i_fault_far_side (.clock(clock), .rst(rst),
    .low_side_drive(low_side_drive), .overload(overload), .reverse(reverse), .sink(sink),
    .demand(demand), .valley_trip(valley_trip), .sink_trip(sink_trip),
    .current_sense_pos_below(current_sense_pos_below), .pwm_compare(pwm_compare));

  initial
  begin
    forever #2.5 clock = ~clock;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1)
    begin
      miscompares++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask

  // Steps clocks and gathers drive statistics; hiccup count never clears
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge clock);
      #1;
      hs += int'(high_side_drive);
      ls += int'(low_side_drive);
      hic += int'(hiccup_active);
      if (hiccup_active === 1'b1 && {high_side_drive, low_side_drive, output_ok_flag_oe_n} !== 3'h0)
        bad++;
    end
  endtask

  task automatic run(input int cycles);
    hs = 0;
    ls = 0;
    tick(cycles * P);
  endtask

  task automatic wait_hic(input logic lvl, input int limit_set_input, output int n);
    n = 0;
    while (hiccup_active !== lvl && n < limit_set_input)
    begin
      tick(1);
      n++;
    end
    if (n >= limit_set_input)
    begin
      miscompares++;
      $display("Error at %0t: hiccup wait timed out", $time);
      finish_test();
    end
  endtask

  initial
  begin
    hs = 0;
    ls = 0;
    hic = 0;
    bad = 0;
    repeat (4) @(posedge clock);
    #1;
    rst = 0;
    check(high_side_drive === 1'b0 && low_side_drive === 1'b0, "drives after reset");
    run(40);
    check(hs == 0 && ls == 0, "switching before first pulse");
    check(ref_level === 7'h01, "first reference step");
    check(output_ok_flag_oe_n === 1'b1, "flag not released");
    output_ok_flag_compare = 0;
    tick(4);
    check(output_ok_flag_oe_n === 1'b0, "flag not pulled low");
    output_ok_flag_compare = 1;
    run(30);
    check(ref_level === 7'h02, "second reference step");
    for (int i = 0; i < 8; i++)
    begin
      d = (i < 2) ? 24 + i : int'(xs() % 32'd40) + 1;
      demand = 8'(d);
      run(2);
      run(2);
      check((hs > 0) == (d >= MIN_ON_CLKS), "short pulse handling");
    end
    demand = 8'h1E;
    run(2);
    t = int'(ref_level);
    overload = 1;
    run(1);
    check(ref_level === 7'(t - 1), "reference roll-back");
    overload = 0;
    run(1);
    check(hs < 8, "pulse after valley cycle");
    run(40);
    check(ref_level > 7'(t - 1), "reference recovery");
    overload = 1;
    run(2);
    overload = 0;
    run(5);
    overload = 1;
    run(2);
    overload = 0;
    run(1);
    check(hic == 0, "counter below zero");
    overload = 1;
    wait_hic(1'b1, 12 * P, t);
    // Previous burst left the count at one, so six more valley cycles fill it
    check(t > 5 * P && t <= 6 * P, "hiccup entry count");
    overload = 0;
    wait_hic(1'b0, (HC + 2) * P, t);
    check(t >= (HC - 1) * P && t <= HC * P + 2, "hiccup timeout length");
    check(bad == 0, "drives or flag during hiccup");
    check(ref_level === REF_RESET, "restart reference");
    t = hic;
    overload = 1;
    reverse = 1;
    run(10);
    check(hic == t && hs > 0, "valley judged while sinking");
    overload = 0;
    run(3);
    sink = 1;
    run(3);
    check(ls < 12, "sink limit low side");
    sink = 0;
    reverse = 0;
    run(20);
    for (int i = 0; i < 2; i++)
    begin
      {uvlo_flag, overtemp_flag} = (i == 0) ? 2'h2 : 2'h1;
      tick(4);
      run(2);
      check(hs == 0 && ls == 0 && output_ok_flag_oe_n === 1'b0, "lockout drives");
      check(ref_level === REF_RESET && output_ok_flag_out === 1'b0, "soft-start reset");
      {uvlo_flag, overtemp_flag} = 2'h0;
      run(40);
      check(ref_level === 7'h01, "fresh soft-start");
    end
    finish_test();
  end
endmodule
